// file: rtl/srcx_top.sv
// What this block does
// R1: port enable takes pins; off holds reset
// R2: master single receive, cleared when done
// R3: continuous receive enables, overrides single
// R4: framing flag per byte; overrun till cleared
// R5: ninth bit shown; address mode filters frames
`timescale 1ns/1ns
`default_nettype none
module srcx_top
  import srcx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic rx_pin,
  input wire logic ck_pin_i,
  output logic ck_pin_o,
  output logic ck_pin_oe
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic rx_m_r, rx_s_r; // data pin, two stages
  logic ck_m_r, ck_s_r; // clock pin, two stages
  // only the second stage is read anywhere
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      ck_m_r <= 1'b0;
      ck_s_r <= 1'b0;
    end else begin
      rx_m_r <= rx_pin;
      rx_s_r <= rx_m_r;
      ck_m_r <= ck_pin_i;
      ck_s_r <= ck_m_r;
    end
  end

  // ----------------------------------------
  // control and status state
  // ----------------------------------------
  logic serial_port_on_r, serial_port_on_nxt; // serial_port_on
  logic nine_r, nine_nxt; // ninth_bit_receive_select
  logic single_receive_request_r, single_receive_request_nxt; // single_receive_request
  logic continuous_receive_on_r, continuous_receive_on_nxt; // continuous_receive_on
  logic addr_r, addr_nxt; // address_match_on
  logic framing_fault_flag_r, framing_fault_flag_nxt; // framing_fault_flag
  logic overrun_fault_flag_r, overrun_fault_flag_nxt; // overrun_fault_flag
  logic received_ninth_bit_r, received_ninth_bit_nxt; // received_ninth_bit
  logic [7:0] buf_r, buf_nxt; // receive_buffer
  logic full_r, full_nxt; // buffer holds an unread byte
  logic sync_r, sync_nxt; // clocked link mode
  logic mstr_r, mstr_nxt; // we drive the link clock
  logic [2:0] sts_r, sts_nxt; // sticky interrupt status
  logic [2:0] mask_r, mask_nxt; // interrupt mask
  logic [7:0] rdata_r, rdata_nxt; // read answer
  logic irq_r, irq_nxt;
  logic ck_o_r, ck_oe_r; // link clock pin drive
  logic eng_ck; // engine's own link clock
  logic eng_rst; // engine reset, port off counts too
  logic wr_rsc, wr_mode, wr_sts, wr_mask; // write decodes
  logic rd_buf; // buffer read, pops the byte
  logic accept; // frame passes address filter
  logic unread; // buffer still occupied this cycle

  srcx_eng_if ifc ();

  // ----------------------------------------
  // engine and its controls
  // ----------------------------------------
  assign eng_rst = rst || !serial_port_on_r; // R1
  // overrun stalls further reception until software clears it
  always_comb begin
    ifc.sync_mode = sync_r;
    ifc.master = mstr_r;
    ifc.nine = nine_r;
    if (!serial_port_on_r || overrun_fault_flag_r) ifc.run = 1'b0;
    else if (!sync_r) ifc.run = continuous_receive_on_r; // R3
    else ifc.run = continuous_receive_on_r || (mstr_r && single_receive_request_r); // R2 R3
  end

  srcx_engine u_eng (
    .mclk(mclk),
    .rst(eng_rst),
    .rx_s(rx_s_r),
    .ck_s(ck_s_r),
    .ck_o(eng_ck),
    .ifc(ifc.eng)
  );

  // ----------------------------------------
  // register decode and next values
  // ----------------------------------------
  assign wr_rsc = reg_wr && reg_addr == ADDR_RSC;
  assign wr_mode = reg_wr && reg_addr == ADDR_MODE;
  assign wr_sts = reg_wr && reg_addr == ADDR_IRQ_STS;
  assign wr_mask = reg_wr && reg_addr == ADDR_IRQ_MASK;
  assign rd_buf = reg_rd && reg_addr == ADDR_RXBUF;
  // in async nine-bit address mode only frames with the top bit set count
  assign accept = ifc.done && !(nine_r && addr_r && !sync_r && !ifc.data[8]); // R5
  assign unread = full_r && !rd_buf;

  always_comb begin
    serial_port_on_nxt = serial_port_on_r;
    nine_nxt = nine_r;
    single_receive_request_nxt = single_receive_request_r;
    continuous_receive_on_nxt = continuous_receive_on_r;
    addr_nxt = addr_r;
    framing_fault_flag_nxt = framing_fault_flag_r;
    overrun_fault_flag_nxt = overrun_fault_flag_r;
    received_ninth_bit_nxt = received_ninth_bit_r;
    buf_nxt = buf_r;
    full_nxt = full_r;
    sync_nxt = sync_r;
    mstr_nxt = mstr_r;
    mask_nxt = mask_r;
    // write one to clear, events below win
    sts_nxt = sts_r & ~(wr_sts ? reg_wdata[2:0] : 3'h0);
    // low three bits of the control register are read only
    if (wr_rsc) begin
      serial_port_on_nxt = reg_wdata[B_SERIAL_PORT_ON];
      nine_nxt = reg_wdata[B_NINE];
      single_receive_request_nxt = reg_wdata[B_SINGLE_RECEIVE_REQUEST];
      continuous_receive_on_nxt = reg_wdata[B_CONTINUOUS_RECEIVE_ON];
      addr_nxt = reg_wdata[B_ADDR];
    end
    if (wr_mode) begin
      sync_nxt = reg_wdata[M_SYNC];
      mstr_nxt = reg_wdata[M_MASTER];
    end
    if (wr_mask) mask_nxt = reg_wdata[2:0];
    if (rd_buf) full_nxt = 1'b0;
    // clearing continuous receive or switching the port off are the only ways out of overrun
    if (wr_rsc && !reg_wdata[B_CONTINUOUS_RECEIVE_ON]) overrun_fault_flag_nxt = 1'b0; // R4
    // single request ends with its frame, unless continuous overrides
    if (ifc.done && sync_r && mstr_r && !continuous_receive_on_r) single_receive_request_nxt = 1'b0; // R2 R3
    if (accept) begin
      if (unread) begin
        overrun_fault_flag_nxt = 1'b1; // R4
        sts_nxt[I_OVERRUN_FAULT_FLAG] = 1'b1;
      end else begin
        buf_nxt = ifc.data[7:0];
        received_ninth_bit_nxt = ifc.data[8]; // R5
        framing_fault_flag_nxt = ifc.fault; // R4
        full_nxt = 1'b1;
        sts_nxt[I_RXD] = 1'b1;
        if (ifc.fault) sts_nxt[I_FRAMING_FAULT_FLAG] = 1'b1;
      end
    end
    // port off: fault flags and buffer-full flag held clear, buffer and ninth bit kept
    if (!serial_port_on_r) begin
      framing_fault_flag_nxt = 1'b0; // R1
      overrun_fault_flag_nxt = 1'b0;
      full_nxt = 1'b0;
    end
    // read answer stands one cycle only
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_RSC: rdata_nxt = {serial_port_on_r, nine_r, single_receive_request_r, continuous_receive_on_r, addr_r,
                               framing_fault_flag_r, overrun_fault_flag_r, received_ninth_bit_r};
        ADDR_RXBUF: rdata_nxt = buf_r;
        ADDR_MODE: rdata_nxt = {6'h00, mstr_r, sync_r};
        ADDR_IRQ_STS: rdata_nxt = {5'h00, sts_r};
        ADDR_IRQ_MASK: rdata_nxt = {5'h00, mask_r};
        default: rdata_nxt = 8'h00; // unmapped reads zero
      endcase
    end
    irq_nxt = |(sts_nxt & mask_nxt);
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      {serial_port_on_r, nine_r, single_receive_request_r, continuous_receive_on_r, addr_r, framing_fault_flag_r, overrun_fault_flag_r, received_ninth_bit_r} <= RSC_RST;
      buf_r <= 8'h00;
      full_r <= 1'b0;
      {mstr_r, sync_r} <= MODE_RST;
      sts_r <= 3'h0;
      mask_r <= MASK_RST;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      ck_o_r <= 1'b0;
      ck_oe_r <= 1'b0;
    end else begin
      serial_port_on_r <= serial_port_on_nxt;
      nine_r <= nine_nxt;
      single_receive_request_r <= single_receive_request_nxt;
      continuous_receive_on_r <= continuous_receive_on_nxt;
      addr_r <= addr_nxt;
      framing_fault_flag_r <= framing_fault_flag_nxt;
      overrun_fault_flag_r <= overrun_fault_flag_nxt;
      received_ninth_bit_r <= received_ninth_bit_nxt;
      buf_r <= buf_nxt;
      full_r <= full_nxt;
      sync_r <= sync_nxt;
      mstr_r <= mstr_nxt;
      sts_r <= sts_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      ck_o_r <= eng_ck;
      ck_oe_r <= serial_port_on_r && sync_r && mstr_r; // R1
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign ck_pin_o = ck_o_r;
  assign ck_pin_oe = ck_oe_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_PORT_OFF: assert property ( // R1
    !serial_port_on_r ##1 !serial_port_on_r |-> !full_r && !overrun_fault_flag_r && !framing_fault_flag_r && !ck_pin_oe)
    else $error("port off but receive state or clock drive active");

  AST_SINGLE_CLEAR: assert property ( // R2
    ifc.done && sync_r && mstr_r && !continuous_receive_on_r && single_receive_request_r && serial_port_on_r && !wr_rsc
    |=> !single_receive_request_r && !ifc.run)
    else $error("single receive request not cleared after frame");

  AST_CONT_KEEP: assert property ( // R3
    ifc.done && sync_r && continuous_receive_on_r && single_receive_request_r && !wr_rsc |=> single_receive_request_r)
    else $error("single request cleared while continuous receive set");

  AST_ASYNC_OFF: assert property ( // R3
    serial_port_on_r && !sync_r && !continuous_receive_on_r |-> !ifc.run)
    else $error("async receiver running with continuous receive off");

  AST_OVR_SET: assert property ( // R4
    serial_port_on_r && accept && full_r && !rd_buf |=> overrun_fault_flag_r && sts_r[I_OVERRUN_FAULT_FLAG] ##1 overrun_fault_flag_r)
    else $error("overrun not flagged and held");

  AST_OVR_HOLD: assert property ( // R4
    overrun_fault_flag_r && serial_port_on_r && !wr_rsc |=> overrun_fault_flag_r)
    else $error("overrun cleared without clearing continuous receive");

  AST_FRAMING_FAULT_FLAG_LOAD: assert property ( // R4
    serial_port_on_r && accept && !unread |=> framing_fault_flag_r == $past(ifc.fault) && full_r)
    else $error("framing flag does not follow stored frame");

  AST_ADDR_DROP: assert property ( // R5
    ifc.done && nine_r && addr_r && !sync_r && !ifc.data[8] && !rd_buf
    |=> $stable(buf_r) && $stable(received_ninth_bit_r))
    else $error("address mode accepted a frame with ninth bit clear");

  AST_RECEIVED_NINTH_BIT: assert property ( // R5
    serial_port_on_r && accept && !unread |=> received_ninth_bit_r == $past(ifc.data[8]))
    else $error("received ninth bit not presented");

  // master mode: the clock pin is ours one cycle later
  AST_CK_DRIVE: assert property ( // R1
    serial_port_on_r && sync_r && mstr_r |=> ck_pin_oe)
    else $error("clock pin not driven in master mode");

  // a port that stays off never reports a frame
  AST_ENG_HELD: assert property ( // R1
    !serial_port_on_r ##1 !serial_port_on_r |-> !ifc.done)
    else $error("engine reported a frame while port off");

  // slave mode ignores the single request
  AST_SLAVE_SINGLE: assert property ( // R2
    serial_port_on_r && sync_r && !mstr_r && !continuous_receive_on_r |-> !ifc.run)
    else $error("slave receiver started by single request");

  // master single request keeps the receiver running
  AST_SINGLE_RUN: assert property ( // R2
    serial_port_on_r && sync_r && mstr_r && single_receive_request_r && !overrun_fault_flag_r |-> ifc.run)
    else $error("master single request did not run receiver");

  // continuous receive runs the receiver in every mode
  AST_CONT_RUN: assert property ( // R3
    serial_port_on_r && continuous_receive_on_r && !overrun_fault_flag_r |-> ifc.run)
    else $error("continuous receive set but receiver stopped");

  // an overrun stalls reception until it is cleared
  AST_OVR_STALL: assert property ( // R4
    overrun_fault_flag_r |-> !ifc.run)
    else $error("receiver running during overrun");

  // with the port on, framing flag only moves with a stored frame
  AST_FRAMING_FAULT_FLAG_HOLD: assert property ( // R4
    framing_fault_flag_r && serial_port_on_r && !accept |=> framing_fault_flag_r)
    else $error("framing flag changed without a stored frame");

  COV_SINGLE: cover property (ifc.done && sync_r && mstr_r && !continuous_receive_on_r);
  COV_SLAVE: cover property (ifc.done && sync_r && !mstr_r);
  COV_OVERRUN: cover property (!overrun_fault_flag_r ##1 overrun_fault_flag_r);
  COV_FRAMING: cover property (accept && ifc.fault);
  COV_ASYNC: cover property (accept && !sync_r && !ifc.fault);
endmodule : srcx_top
`default_nettype wire

// file: rtl/srcx_pkg.sv
// ----------------------------------------
// constants of the receive control block
// ----------------------------------------
package srcx_pkg;
  // clock and link timing
  localparam int CLK_NS = 100;
  localparam int ASYNC_BIT_NS = 800;
  localparam int SYNC_HALF_NS = 400;
  localparam logic [15:0] ASYNC_BIT_CYC = 16'(ASYNC_BIT_NS / CLK_NS);
  localparam logic [15:0] ASYNC_HALF_CYC = 16'(ASYNC_BIT_NS / CLK_NS / 2);
  localparam logic [15:0] SYNC_HALF_CYC = 16'(SYNC_HALF_NS / CLK_NS);
  // register offsets
  localparam logic [2:0] ADDR_RSC = 3'h0;
  localparam logic [2:0] ADDR_RXBUF = 3'h1;
  localparam logic [2:0] ADDR_MODE = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STS = 3'h3;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;
  // receive_status_control field positions
  localparam int B_SERIAL_PORT_ON = 7;
  localparam int B_NINE = 6;
  localparam int B_SINGLE_RECEIVE_REQUEST = 5;
  localparam int B_CONTINUOUS_RECEIVE_ON = 4;
  localparam int B_ADDR = 3;
  localparam int B_FRAMING_FAULT_FLAG = 2;
  localparam int B_OVERRUN_FAULT_FLAG = 1;
  localparam int B_RECEIVED_NINTH_BIT = 0;
  // mode register field positions
  localparam int M_SYNC = 0;
  localparam int M_MASTER = 1;
  // interrupt status and mask positions
  localparam int I_RXD = 0;
  localparam int I_FRAMING_FAULT_FLAG = 1;
  localparam int I_OVERRUN_FAULT_FLAG = 2;
  // reset values
  localparam logic [7:0] RSC_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  // engine states
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} srcx_state_t;
endpackage : srcx_pkg

// file: rtl/srcx_eng_if.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// control and frame results, top to engine
// ----------------------------------------
interface srcx_eng_if;
  logic run; // receiver may run
  logic sync_mode; // clocked link instead of start/stop
  logic master; // we make the link clock
  logic nine; // nine data bits
  logic done; // one-cycle frame finished
  logic [8:0] data; // frame, ninth bit on top
  logic fault; // stop bit was low
  modport eng (input run, input sync_mode, input master, input nine,
               output done, output data, output fault);
  modport ctl (output run, output sync_mode, output master, output nine,
               input done, input data, input fault);
endinterface : srcx_eng_if
`default_nettype wire

// file: rtl/srcx_engine.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// bit engine: start/stop or clocked capture
// ----------------------------------------
module srcx_engine
  import srcx_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic rx_s,
  input wire logic ck_s,
  output logic ck_o,
  srcx_eng_if.eng ifc
);
  srcx_state_t st_r, st_nxt; // frame state
  logic [15:0] cnt_r, cnt_nxt; // cycle counter
  logic [3:0] bits_r, bits_nxt; // bits taken
  logic [8:0] sh_r, sh_nxt; // shift register, lsb first
  logic ck_prev_r; // last sampled link clock
  logic ck_gen_r, ck_gen_nxt; // own link clock
  logic done_r, done_nxt;
  logic fault_r, fault_nxt;
  logic [8:0] data_r, data_nxt;
  logic [3:0] last_bit; // index of final data bit
  logic rise; // link clock rising, either source
  logic [8:0] sh_in; // shift register with new bit
  assign last_bit = ifc.nine ? 4'h8 : 4'h7;
  assign sh_in = {rx_s, sh_r[8:1]};
  // slave edge is seen late by the synchroniser, which is fine at 8x oversampling
  assign rise = ifc.master ? (cnt_r == SYNC_HALF_CYC - 16'h1 && !ck_gen_r)
                           : (ck_s && !ck_prev_r);
  // next state of the engine
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    bits_nxt = bits_r;
    sh_nxt = sh_r;
    ck_gen_nxt = ck_gen_r;
    done_nxt = 1'b0;
    fault_nxt = fault_r;
    data_nxt = data_r;
    if (!ifc.run) begin
      st_nxt = ST_IDLE;
      cnt_nxt = 16'h0;
      bits_nxt = 4'h0;
      ck_gen_nxt = 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          cnt_nxt = 16'h0;
          bits_nxt = 4'h0;
          if (ifc.sync_mode) st_nxt = ST_DATA;
          else if (!rx_s) st_nxt = ST_START; // falling start edge
        end
        ST_START: begin
          cnt_nxt = cnt_r + 16'h1;
          if (cnt_r == ASYNC_HALF_CYC - 16'h1) begin
            cnt_nxt = 16'h0;
            // a short low pulse is noise, not a start bit
            st_nxt = rx_s ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (ifc.sync_mode) begin
            if (ifc.master) begin
              cnt_nxt = cnt_r + 16'h1;
              if (cnt_r == SYNC_HALF_CYC - 16'h1) begin
                cnt_nxt = 16'h0;
                ck_gen_nxt = !ck_gen_r;
              end
            end
            if (rise) begin
              sh_nxt = sh_in;
              bits_nxt = bits_r + 4'h1;
              if (bits_r == last_bit) begin
                done_nxt = 1'b1;
                fault_nxt = 1'b0;
                data_nxt = ifc.nine ? sh_in : {1'b0, sh_in[8:1]};
                st_nxt = ST_IDLE;
              end
            end
          end else begin
            cnt_nxt = cnt_r + 16'h1;
            if (cnt_r == ASYNC_BIT_CYC - 16'h1) begin
              cnt_nxt = 16'h0;
              sh_nxt = sh_in;
              bits_nxt = bits_r + 4'h1;
              if (bits_r == last_bit) st_nxt = ST_STOP;
            end
          end
        end
        ST_STOP: begin
          cnt_nxt = cnt_r + 16'h1;
          if (cnt_r == ASYNC_BIT_CYC - 16'h1) begin
            done_nxt = 1'b1;
            fault_nxt = !rx_s; // stop bit must be high
            data_nxt = ifc.nine ? sh_r : {1'b0, sh_r[8:1]};
            st_nxt = ST_IDLE;
          end
        end
      endcase
    end
  end
  // engine registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      cnt_r <= 16'h0;
      bits_r <= 4'h0;
      sh_r <= 9'h000;
      ck_prev_r <= 1'b0;
      ck_gen_r <= 1'b0;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      data_r <= 9'h000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bits_r <= bits_nxt;
      sh_r <= sh_nxt;
      ck_prev_r <= ck_s;
      ck_gen_r <= ck_gen_nxt;
      done_r <= done_nxt;
      fault_r <= fault_nxt;
      data_r <= data_nxt;
    end
  end
  assign ck_o = ck_gen_r;
  assign ifc.done = done_r;
  assign ifc.fault = fault_r;
  assign ifc.data = data_r;
endmodule : srcx_engine
`default_nettype wire

// file: verification/srcx_link_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// far side: remote transmitter or clock partner
// ----------------------------------------
module srcx_link_model (
  input wire logic ck_o,
  output logic rx,
  output logic ck
);
  // line idles high, partner clock idles low
  initial begin
    rx = 1'b1;
    ck = 1'b0;
  end
  // start/stop frame, lsb first; stp low forces a bad stop bit
  task automatic send_async(input logic [8:0] d, input int n, input logic stp);
    #30;
    rx = 1'b0;
    #800;
    for (int i = 0; i < n; i++) begin
      rx = d[i];
      #800;
    end
    rx = stp;
    #800;
    rx = 1'b1;
  endtask : send_async
  // device makes the clock: new bit after each falling edge
  task automatic serve_master(input logic [8:0] d, input int n);
    rx = d[0];
    for (int i = 1; i < n; i++) begin
      @(negedge ck_o);
      rx = d[i];
    end
    @(posedge ck_o);
    #200;
    // hold over: released line shows the inverse, not a stale bit
    rx = ~rx;
  endtask : serve_master
  // we make the clock, only within the frame
  task automatic drive_slave(input logic [8:0] d, input int n);
    #30;
    for (int i = 0; i < n; i++) begin
      rx = d[i];
      #400 ck = 1'b1;
      #400 ck = 1'b0;
    end
    rx = ~rx;
  endtask : drive_slave
endmodule : srcx_link_model
`default_nettype wire

// file: verification/srcx_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module srcx_tb_top;
  import srcx_pkg::*;
  // ----------------------------------------
  // clock, reset, bus and pins
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq;
  logic rx_pin;
  logic ck_pin_o, ck_pin_oe, lm_ck;
  wire logic ck_wire = ck_pin_oe ? ck_pin_o : lm_ck; // resolved clock pin
  int error_cnt = 0;
  int n_tests = 0;
  always #50 mclk = ~mclk; // 10 MHz
  srcx_top uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .rx_pin(rx_pin),
    .ck_pin_i(ck_wire), .ck_pin_o(ck_pin_o), .ck_pin_oe(ck_pin_oe));
  srcx_link_model lm (.ck_o(ck_pin_o), .rx(rx_pin), .ck(lm_ck));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // read, data only in the following cycle; m hides fields left open
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, e & m);
  endtask : rd
  task automatic conclude;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values, unmapped index reads zero
  task automatic t_reset;
    rd(ADDR_RSC, RSC_RST, 8'hff);
    rd(ADDR_MODE, 8'h00, 8'hff);
    rd(ADDR_IRQ_MASK, 8'h00, 8'hff);
    rd(3'h5, 8'h00, 8'hff);
  endtask : t_reset
  // plain async byte, interrupt raised then cleared
  task automatic t_async;
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_RSC, 8'h90);
    lm.send_async(9'h0a5, 8, 1'b1);
    repeat (4) @(posedge mclk);
    #1;
    chk({7'h0, irq}, 8'h01);
    rd(ADDR_IRQ_STS, 8'h01, 8'hff);
    rd(ADDR_RXBUF, 8'ha5, 8'hff);
    rd(ADDR_RSC, 8'h90, 8'hfe);
    wr(ADDR_IRQ_STS, 8'h01);
    @(posedge mclk);
    #1;
    chk({7'h0, irq}, 8'h00);
  endtask : t_async
  // bad stop bit, then a frame into a full buffer
  task automatic t_errors;
    lm.send_async(9'h03c, 8, 1'b0);
    repeat (4) @(posedge mclk);
    rd(ADDR_RSC, 8'h94, 8'hfe);
    lm.send_async(9'h0c3, 8, 1'b1);
    repeat (4) @(posedge mclk);
    rd(ADDR_RSC, 8'h96, 8'hfe);
    rd(ADDR_RXBUF, 8'h3c, 8'hff);
    wr(ADDR_RSC, 8'h80);
    rd(ADDR_RSC, 8'h00, 8'h02);
    // port off wipes the framing flag (overrun already went with continuous off), not the interrupt status
    wr(ADDR_RSC, 8'h00);
    rd(ADDR_RSC, 8'h00, 8'hff);
    wr(ADDR_IRQ_STS, 8'h07);
  endtask : t_errors
  // nine bits with and without address filtering
  task automatic t_nine;
    wr(ADDR_RSC, 8'hd8);
    lm.send_async(9'h055, 9, 1'b1);
    repeat (4) @(posedge mclk);
    rd(ADDR_IRQ_STS, 8'h00, 8'h01);
    lm.send_async(9'h1aa, 9, 1'b1);
    repeat (4) @(posedge mclk);
    rd(ADDR_RSC, 8'hd9, 8'hff);
    rd(ADDR_RXBUF, 8'haa, 8'hff);
    wr(ADDR_RSC, 8'hd0);
    lm.send_async(9'h033, 9, 1'b1);
    repeat (4) @(posedge mclk);
    rd(ADDR_RSC, 8'hd0, 8'hff);
    rd(ADDR_RXBUF, 8'h33, 8'hff);
    wr(ADDR_IRQ_STS, 8'h07);
  endtask : t_nine
  // receiver off: a frame leaves no trace
  task automatic t_cont_off;
    wr(ADDR_RSC, 8'h80);
    lm.send_async(9'h011, 8, 1'b1);
    repeat (4) @(posedge mclk);
    rd(ADDR_IRQ_STS, 8'h00, 8'hff);
  endtask : t_cont_off
  // clocked master, one frame on request
  task automatic t_master;
    wr(ADDR_MODE, 8'h03);
    wr(ADDR_RSC, 8'ha0);
    #1;
    chk({7'h0, ck_pin_oe}, 8'h01);
    lm.serve_master(9'h05a, 8);
    repeat (10) @(posedge mclk);
    rd(ADDR_RSC, 8'h80, 8'hf0);
    rd(ADDR_RXBUF, 8'h5a, 8'hff);
    // link clock parked low once the single frame is over
    chk({7'h0, ck_pin_o}, 8'h00);
    wr(ADDR_RSC, 8'h00);
    // pin drive is registered: released one cycle after port off
    @(posedge mclk);
    #1;
    chk({7'h0, ck_pin_oe}, 8'h00);
  endtask : t_master
  // clocked slave: single request ignored, continuous stays on
  task automatic t_slave;
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_RSC, 8'ha0);
    lm.drive_slave(9'h03c, 8);
    repeat (10) @(posedge mclk);
    rd(ADDR_RXBUF, 8'h5a, 8'hff);
    wr(ADDR_RSC, 8'h90);
    lm.drive_slave(9'h0c3, 8);
    repeat (10) @(posedge mclk);
    rd(ADDR_RXBUF, 8'hc3, 8'hff);
    rd(ADDR_RSC, 8'h90, 8'hf0);
  endtask : t_slave
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_async();
    t_errors();
    wr(ADDR_IRQ_MASK, 8'h00);
    t_nine();
    t_cont_off();
    t_master();
    t_slave();
    conclude();
  end
  // whole run needs well under a millisecond
  initial begin
    #2000000;
    error_cnt++;
    conclude();
  end
endmodule : srcx_tb_top
`default_nettype wire
